// >>> rtl/ratio_pkg.sv
package ratio_pkg;

  // Core-to-bus multiplier held in half steps: value = 2 x multiplier
  localparam logic [4:0] MULT_HALF_MIN = 5'h0c;    // 6
  localparam logic [4:0] MULT_HALF_MAX = 5'h13;    // 9.5
  localparam logic [4:0] MULT_HALF_BAD = 5'h0d;    // 6.5 is not offered

  // Bus frequency select codes; every other code is reserved
  localparam logic [2:0] FREQ_SEL_266 = 3'h0;
  localparam logic [2:0] FREQ_SEL_333 = 3'h4;
  localparam logic [2:0] FREQ_SEL_400 = 3'h6;

  // Bus rate grades held in the factory store
  localparam logic [1:0] GRADE_266 = 2'h0;
  localparam logic [1:0] GRADE_333 = 2'h1;
  localparam logic [1:0] GRADE_400 = 2'h2;

  // Values after reset
  localparam logic [4:0] RST_MULT_HALF = 5'h0c;
  localparam logic [2:0] RST_BUS_SEL = 3'h0;

  typedef enum logic [1:0] {
    ST_RESET = 2'h0,
    ST_LOAD = 2'h1,
    ST_RUN = 2'h3
  } cfg_state_t;

endpackage

// >>> rtl/mult_if.sv
`timescale 1ns/1ps
// Multiplier handed from the configuration logic to the tick generator
interface mult_if;
  logic [4:0] mult_half;
  logic run;
  modport src (output mult_half, output run);
  modport dst (input mult_half, input run);
endinterface

// >>> rtl/core_tick_gen.sv
`timescale 1ns/1ps
// Fractional tick generator: emits mult_half core ticks per bus cycle,
// two phases per bus cycle so that half multipliers come out exact.
module core_tick_gen
  import ratio_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rst,
  mult_if.dst m,
  output logic [4:0] o_ticks
);

  logic phase_r;
  logic [4:0] ticks_r;
  logic [4:0] ticks_nxt;
  logic phase_nxt;

  // Odd half-multipliers split as floor and ceil over the two half cycles; one phase bit is all the state needed
  assign phase_nxt = ~phase_r;
  assign ticks_nxt = phase_r ? (m.mult_half - (m.mult_half >> 1)) : (m.mult_half >> 1);

  // Ticks per half bus cycle; two consecutive values sum to mult_half
  always_ff @(posedge i_core_clk) begin
    if (i_rst || !m.run) begin
      phase_r <= 1'b0;
      ticks_r <= 5'h00;
    end else begin
      phase_r <= phase_nxt;
      ticks_r <= ticks_nxt;
    end
  end

  assign o_ticks = ticks_r;

  AST_TICK_PAIR: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (m.run && $past(m.run) && $past(m.run, 2) && $stable(m.mult_half) && $past(m.mult_half) == $past(m.mult_half, 2))
      |-> (5'(o_ticks + $past(o_ticks)) == m.mult_half))
    else $error("tick pair does not sum to multiplier");

endmodule

// >>> rtl/bus_ratio_and_freq_select.sv
`timescale 1ns/1ps
// Operation
// - Core ticks follow selected multiplier per bus clock
// - Factory multiplier defaults to rated top speed
// - Load stored maximum multiplier in the two cycles after reset release
// - Software may lower multiplier, never above max
// - Multipliers 6 to 9.5 in half steps, except 6.5
// - Select codes 000, 100, 110 for bus rates
// - Power-up select shows part's top bus rate
// - All bus agents share one frequency
module bus_ratio_and_freq_select
  import ratio_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic [4:0] i_fuse_mult_half,
  input wire logic [1:0] i_fuse_bus_grade,
  input wire logic i_limit_wr,
  input wire logic [4:0] i_limit_mult_half,
  output logic [4:0] o_mult_half,
  output logic o_limit_rejected,
  output logic [2:0] o_bus_freq_select_out,
  output logic o_cfg_ready,
  output logic [4:0] o_core_ticks
);

  ////////////////////////////////////////////////////////////////////////////
  // Decoding helpers

  // 6.5 is the one gap in the half-step range, so it is refused by name
  // A half-step value is legal if inside 6..9.5 and not 6.5
  function automatic logic mult_ok(input logic [4:0] v);
    mult_ok = (v >= MULT_HALF_MIN) && (v <= MULT_HALF_MAX) && (v != MULT_HALF_BAD);
  endfunction

  // Map a grade to its select code; unknown grades fall to the slowest rate
  function automatic logic [2:0] grade_code(input logic [1:0] g);
    case (g)
      GRADE_400: grade_code = FREQ_SEL_400;
      GRADE_333: grade_code = FREQ_SEL_333;
      default: grade_code = FREQ_SEL_266;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State and registers

  cfg_state_t state_r;
  cfg_state_t state_nxt;
  logic [4:0] max_mult_r;
  logic [4:0] cur_mult_r;
  logic [4:0] cur_mult_nxt;
  logic [2:0] bus_sel_r;
  logic rej_r;
  logic rej_nxt;
  logic fuse_ok;
  logic [4:0] fuse_mult;
  logic limit_ok;
  logic limit_take;

  mult_if mlink();

  // A bad fuse value falls back to the slowest legal multiplier
  assign fuse_ok = mult_ok(i_fuse_mult_half);
  assign fuse_mult = fuse_ok ? i_fuse_mult_half : MULT_HALF_MIN;

  // Raising back up is allowed; only the stored ceiling itself is hard
  // A request is honoured only if legal and not above the stored ceiling
  assign limit_ok = mult_ok(i_limit_mult_half) && (i_limit_mult_half <= max_mult_r);
  assign limit_take = (state_r == ST_RUN) && i_limit_wr && limit_ok;

  ////////////////////////////////////////////////////////////////////////////
  // Configuration sequence: straps are caught on the first cycle after reset

  // Reset, one capture cycle, one load cycle, then run until the next reset
  always_comb begin
    case (state_r)
      ST_RESET: state_nxt = ST_LOAD;
      ST_LOAD: state_nxt = ST_RUN;
      ST_RUN: state_nxt = ST_RUN;
      default: state_nxt = ST_RESET;
    endcase
  end

  // Next multiplier: fuse on load, software sets it at or below the ceiling while running
  always_comb begin
    cur_mult_nxt = cur_mult_r;
    rej_nxt = 1'b0;
    case (state_r)
      // Load the captured ceiling, so a strap moving after capture cannot lift it
      ST_LOAD: cur_mult_nxt = max_mult_r;
      ST_RUN: begin
        if (limit_take) begin
          cur_mult_nxt = i_limit_mult_half;
        end
        rej_nxt = i_limit_wr && !limit_ok;
      end
      default: cur_mult_nxt = cur_mult_r;
    endcase
  end

  // State register
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      state_r <= ST_RESET;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Stored ceiling and select code are caught once, after reset release
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      max_mult_r <= RST_MULT_HALF;
      bus_sel_r <= RST_BUS_SEL;
    end else if (state_r == ST_RESET) begin
      max_mult_r <= fuse_mult;
      bus_sel_r <= grade_code(i_fuse_bus_grade);
    end
  end

  // Working multiplier and the one-cycle refusal pulse
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      cur_mult_r <= RST_MULT_HALF;
      rej_r <= 1'b0;
    end else begin
      cur_mult_r <= cur_mult_nxt;
      rej_r <= rej_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs and core tick generator

  assign mlink.mult_half = cur_mult_r;
  assign mlink.run = (state_r == ST_RUN);

  core_tick_gen u_tick (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .m(mlink.dst),
    .o_ticks(o_core_ticks)
  );

  // Ready is decoded from state; it is a handshake, not data
  assign o_mult_half = cur_mult_r;
  assign o_limit_rejected = rej_r;
  assign o_bus_freq_select_out = bus_sel_r;
  assign o_cfg_ready = (state_r == ST_RUN);

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  AST_NEVER_ABOVE_MAX: assert property (@(posedge i_core_clk) disable iff (i_rst)
    o_cfg_ready |-> (o_mult_half <= max_mult_r))
    else $error("multiplier above stored maximum");

  AST_MULT_LEGAL: assert property (@(posedge i_core_clk) disable iff (i_rst)
    o_cfg_ready |-> ((o_mult_half >= 5'h0c) && (o_mult_half <= 5'h13) && (o_mult_half != 5'h0d)))
    else $error("illegal multiplier in use");

  AST_SEL_LEGAL: assert property (@(posedge i_core_clk) disable iff (i_rst)
    o_cfg_ready |-> (o_bus_freq_select_out inside {3'h0, 3'h4, 3'h6}))
    else $error("reserved select code driven");

  AST_SEL_STABLE: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (o_cfg_ready && $past(o_cfg_ready)) |-> $stable(o_bus_freq_select_out))
    else $error("select code changed after power-up");

  AST_LOAD_FUSE: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (state_r == ST_LOAD) |=> (o_mult_half == $past(max_mult_r)) && o_cfg_ready)
    else $error("stored multiplier not loaded");

  AST_LIMIT_APPLY: assert property (@(posedge i_core_clk) disable iff (i_rst)
    limit_take |=> (o_mult_half == $past(i_limit_mult_half)) && !o_limit_rejected)
    else $error("legal limit not applied");

  AST_LIMIT_REJECT: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (o_cfg_ready && i_limit_wr && !limit_ok) |=> o_limit_rejected && $stable(o_mult_half))
    else $error("illegal limit not refused");

  AST_GRADE_SEL: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (state_r == ST_RESET && i_fuse_bus_grade == 2'h2) |-> ##2 (o_bus_freq_select_out == 3'h6))
    else $error("top grade not shown on select");

  ////////////////////////////////////////////////////////////////////////////
  // Checks on reset, idle, refusal and hold-while-running paths

  // Checked without a disable so that the reset branch itself is covered
  AST_RESET_OUT: assert property (@(posedge i_core_clk)
    i_rst |=> (o_mult_half == RST_MULT_HALF) && !o_cfg_ready && !o_limit_rejected
      && (o_bus_freq_select_out == RST_BUS_SEL) && (o_core_ticks == 5'h00))
    else $error("outputs not at reset values");

  // A refusal pulse must trace back to a bad write taken while running
  AST_REJECT_CAUSE: assert property (@(posedge i_core_clk) disable iff (i_rst)
    o_limit_rejected |-> $past(o_cfg_ready && i_limit_wr && !limit_ok))
    else $error("refusal without a refused write");

  // Writes made before the run state are dropped, neither applied nor refused
  AST_IDLE_WRITE: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (!o_cfg_ready && i_limit_wr) |=> !o_limit_rejected)
    else $error("write before ready was acted on");

  // The ceiling is caught once; nothing but reset may move it afterwards
  AST_MAX_HELD: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (o_cfg_ready && $past(o_cfg_ready)) |-> $stable(max_mult_r))
    else $error("stored maximum moved while running");

  // No core ticks are reported until the multiplier has settled
  AST_TICKS_IDLE: assert property (@(posedge i_core_clk) disable iff (i_rst)
    !o_cfg_ready |=> (o_core_ticks == 5'h00))
    else $error("core ticks before configuration");

  // Select lines move only at the capture cycle, never while the bus runs
  AST_SEL_HELD: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (state_r != ST_RESET) |=> $stable(o_bus_freq_select_out))
    else $error("select code moved outside capture");

endmodule

// >>> sim/bus_agent_model.sv
`timescale 1ns/1ps
// Chipset and clock synthesizer as seen from the select lines
module bus_agent_model (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_cfg_ready,
  input wire logic [2:0] i_bus_freq_select_out,
  output logic [8:0] o_bus_mhz,
  output logic o_fault
);
  logic [2:0] sel_r;
  logic ready_r;
  logic moved;
  ////////////////////////////////////////////////////////////
  // Synthesizer rate; a reserved code gives no bus clock at all
  always_comb begin
    case (i_bus_freq_select_out)
      3'h0: o_bus_mhz = 9'h10a;
      3'h4: o_bus_mhz = 9'h14d;
      3'h6: o_bus_mhz = 9'h190;
      default: o_bus_mhz = 9'h000;
    endcase
  end
  // All agents must share one rate, so a change once configured is fatal
  assign moved = ready_r && (sel_r != i_bus_freq_select_out);
  always_ff @(posedge i_core_clk) begin
    sel_r <= i_bus_freq_select_out;
    ready_r <= i_cfg_ready;
    if (i_rst) begin
      o_fault <= 1'b0;
    end else if (moved || (i_cfg_ready && o_bus_mhz == 9'h000)) begin
      o_fault <= 1'b1;
    end
  end
endmodule

// >>> sim/tb_bus_ratio_and_freq_select.sv
`timescale 1ns/1ps
module tb_bus_ratio_and_freq_select;
  import ratio_pkg::*;
  typedef struct packed {logic [4:0] fm; logic [1:0] gr; logic [4:0] em; logic [2:0] es; logic [8:0] mhz;} row_t;
  logic i_core_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [4:0] i_fuse_mult_half = 5'h13;
  logic [1:0] i_fuse_bus_grade = 2'h2;
  logic i_limit_wr = 1'b0;
  logic [4:0] i_limit_mult_half = 5'h00;
  logic [4:0] o_mult_half;
  logic [4:0] o_core_ticks;
  logic o_limit_rejected;
  logic o_cfg_ready;
  logic [2:0] o_bus_freq_select_out;
  logic [8:0] bus_mhz;
  logic fault;
  int bad_count = 0;
  int compares = 0;
  // Straps in, multiplier and select out; 13 and 20 are illegal straps
  row_t rows [6] = '{{5'h13, 2'h2, 5'h13, 3'h6, 9'h190}, {5'h0c, 2'h0, 5'h0c, 3'h0, 9'h10a},
    {5'h0f, 2'h1, 5'h0f, 3'h4, 9'h14d}, {5'h0d, 2'h3, 5'h0c, 3'h0, 9'h10a},
    {5'h14, 2'h2, 5'h0c, 3'h6, 9'h190}, {5'h11, 2'h1, 5'h11, 3'h4, 9'h14d}};
  ////////////////////////////////////////////////////////////
  // Reference clock of constant period, no modulation
  always #2 i_core_clk = ~i_core_clk;
  bus_ratio_and_freq_select i_dut (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_fuse_mult_half(i_fuse_mult_half),
    .i_fuse_bus_grade(i_fuse_bus_grade), .i_limit_wr(i_limit_wr), .i_limit_mult_half(i_limit_mult_half),
    .o_mult_half(o_mult_half), .o_limit_rejected(o_limit_rejected), .o_bus_freq_select_out(o_bus_freq_select_out),
    .o_cfg_ready(o_cfg_ready), .o_core_ticks(o_core_ticks));
  bus_agent_model i_far (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_cfg_ready(o_cfg_ready),
    .i_bus_freq_select_out(o_bus_freq_select_out), .o_bus_mhz(bus_mhz), .o_fault(fault));
  ////////////////////////////////////////////////////////////
  task automatic cmp(input logic [8:0] got, input logic [8:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Reset with new straps; a pending write is dropped only after edge 2
  task automatic rst(input logic [4:0] fm, input logic [1:0] gr);
    int n;
    @(posedge i_core_clk);
    i_rst <= 1'b1;
    i_fuse_mult_half <= fm;
    i_fuse_bus_grade <= gr;
    repeat (5) @(posedge i_core_clk);
    #1 cmp(9'(o_mult_half), 9'(RST_MULT_HALF));
    cmp(9'(o_cfg_ready), 9'h000);
    cmp(9'(o_core_ticks), 9'h000);
    cmp(9'(o_bus_freq_select_out), 9'(RST_BUS_SEL));
    @(posedge i_core_clk);
    i_rst <= 1'b0;
    repeat (2) @(posedge i_core_clk);
    i_limit_wr <= 1'b0;
    n = 0;
    #1;
    while (o_cfg_ready !== 1'b1) begin
      n++;
      if (n > 8) begin
        bad_count++;
        tally_and_finish();
      end
      @(posedge i_core_clk);
      #1;
    end
  endtask
  // Two consecutive tick counts make one bus cycle
  task automatic ticks(input logic [4:0] em);
    logic [4:0] a;
    repeat (3) @(posedge i_core_clk);
    #1 a = o_core_ticks;
    @(posedge i_core_clk);
    #1 cmp(9'(a) + 9'(o_core_ticks), 9'(em));
  endtask
  // Entered at an edge; strobe stays up for back-to-back writes unless last
  task automatic lim(input logic [4:0] v, input logic [4:0] em, input logic er, input logic last);
    i_limit_wr <= 1'b1;
    i_limit_mult_half <= v;
    @(posedge i_core_clk);
    if (last) i_limit_wr <= 1'b0;
    fork
      begin
        #1 cmp(9'(o_mult_half), 9'(em));
        cmp(9'(o_limit_rejected), 9'(er));
      end
    join_none
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    for (int i = 0; i < 6; i++) begin
      rst(rows[i].fm, rows[i].gr);
      cmp(9'(o_mult_half), 9'(rows[i].em));
      cmp(9'(o_bus_freq_select_out), 9'(rows[i].es));
      cmp(bus_mhz, rows[i].mhz);
      ticks(rows[i].em);
      cmp(9'(fault), 9'h000);
    end
    // Write held across reset release must not land
    @(posedge i_core_clk);
    i_limit_wr <= 1'b1;
    i_limit_mult_half <= 5'h0e;
    rst(5'h13, 2'h2);
    cmp(9'(o_mult_half), 9'h013);
    @(posedge i_core_clk);
    lim(5'h0e, 5'h0e, 1'b0, 1'b0);
    lim(5'h14, 5'h0e, 1'b1, 1'b0);
    lim(5'h0d, 5'h0e, 1'b1, 1'b0);
    lim(5'h0c, 5'h0c, 1'b0, 1'b0);
    lim(5'h12, 5'h12, 1'b0, 1'b0);
    lim(5'h13, 5'h13, 1'b0, 1'b0);
    lim(5'h0f, 5'h0f, 1'b0, 1'b1);
    ticks(5'h0f);
    rst(5'h10, 2'h1);
    @(posedge i_core_clk);
    lim(5'h12, 5'h10, 1'b1, 1'b0);
    lim(5'h11, 5'h10, 1'b1, 1'b0);
    lim(5'h0e, 5'h0e, 1'b0, 1'b1);
    ticks(5'h0e);
    cmp(9'(o_bus_freq_select_out), 9'h004);
    cmp(9'(fault), 9'h000);
    tally_and_finish();
  end
endmodule
